// file: rtl/iss_map.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the register bank and the testbench only
`ifndef ISS_MAP_SVH
`define ISS_MAP_SVH
// register indices; byte address is four times the index
`define ISS_IDX_CHAIN 8'h10
`define ISS_IDX_IFACE 8'h11
`define ISS_IDX_CMD_IDX 8'h11
`define ISS_IDX_TIME 8'h15
`define ISS_IDX_RXHOLD 8'h1b
`define ISS_IDX_EVENT 8'h1c
`define ISS_IDX_RXSTAT 8'h1d
// interface status fields
`define ISS_BIT_UNSOL 0
`define ISS_BIT_STUCK 1
// chain status fields
`define ISS_BIT_CHDONE 7
`define ISS_BIT_CSTATE 5
`define ISS_BIT_POSSDEF 4
`define ISS_BIT_DTXFAIL 3
`define ISS_BIT_PTXFAIL 2
`define ISS_BIT_RXFAIL 1
`define ISS_BIT_RXGOOD 0
// hdlc event fields, all active low
`define ISS_BIT_RXOK 7
`define ISS_BIT_RXERR 6
`define ISS_BIT_TXOK 5
`define ISS_BIT_TXURUN 4
`define ISS_BIT_DISC 3
`define ISS_BIT_RXRDY 2
`define ISS_BIT_TXREQ 1
`define ISS_BIT_ANY 0
// hdlc status fields
`define ISS_BIT_RXIDLE 3
// command register fields and documented command values
`define ISS_BIT_EXEC 7
`define ISS_BIT_STOP 5
`define ISS_BIT_POLL 4
`define ISS_BIT_SPOLL 3
`define ISS_BIT_UNSCH 2
`define ISS_CMD_START_POLL 8'h94
`define ISS_CMD_START 8'h80
`define ISS_CMD_END 8'h84
`define ISS_CMD_STOP 8'h20
`define ISS_CMD_PRIME 8'h00
// reset values
`define ISS_RST_BYTE 8'h00
`define ISS_RST_IDLE8 8'hff
// timing: clock, time byte tick, line idle time
`define ISS_CLK_MHZ 50
`define ISS_TICK_US 66
`define ISS_TICK_CYC (`ISS_TICK_US * `ISS_CLK_MHZ)
`define ISS_IDLE_US 512
`endif

// file: rtl/iss_pkg.sv
// types shared by the status register bank and its surroundings
// assumes iss_map.svh holds the numeric constants
package iss_pkg;
  // poll logic position, codes as read in the chain status field
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_WAIT = 2'b01,
    CS_LOST = 2'b10,
    CS_OWN = 2'b11
  } iss_cstate_type;
  // events reported by the network poll logic
  typedef struct packed {
    logic pollStart;
    logic pollWon;
    logic pollLost;
    logic pollActive;
    logic pollLenBit;
    logic dataLenBit;
    logic cmdTxActive;
    logic rxDataBit;
  } iss_poll_type;
  // events reported by the hdlc receiver
  typedef struct packed {
    logic byteValid;
    logic [7:0] rxByte;
    logic frameEnd;
    logic crcErr;
    logic abortErr;
    logic [2:0] residual;
    logic inFrame;
  } iss_rx_type;
  // memory port used by the sequencer for input and output
  typedef struct packed {
    logic wrEn;
    logic rdReq;
    logic [15:0] addr;
    logic [7:0] wrData;
  } iss_mem_type;
endpackage

// file: rtl/iss_status_regs.sv
// status and command register bank of the i/o sequencer network port
// assumes an ahb-lite master, one clock, synchronous inputs from the
// hdlc receiver/transmitter, the poll logic and the chain engine
//
// Overview of operation
// - unsolicited message end sets flag; host read of that register clears
// - line high for idle time sets stuck flag; any transition clears
// - solicited-to-unsolicited without contend sets done; contend or reverse clears
// - contention field: 00 off, 01 waiting, 10 lost a poll, 11 owner
// - owner sees poll length bit: set default flag; contend cleared resets
// - owner sees data bit on own command frame: set flag; contend cleared resets
// - data length bit during poll sets poll fail; contend cleared resets
// - errored response sets any-fail; new poll or unsol-to-sol clears
// - clean response sets any-good; new poll or unsol-to-sol clears
// - input instruction moves each received byte into dual-port memory
// - event bits seven to three accumulate until the register is read; here bit three is tied high
// - ok-end flag low after clean frame, updated only at closing flag
// - error-end flag low after crc, overrun or abort frame
// - tx done low on clean frame; underrun low when filler inserted
// - rx ready low while byte held; reading holding register sets it
// - tx request low while holding empty; writing a byte sets it
// - summary low when any bit low; read sets; ends instructions
// - receiver idle bit reads zero when no frame in progress
// - after clean frame low status bits count residual bits
// - after errored frame low bits flag abort, overrun, crc
// - byte not taken before the next one is overwritten
// - time byte ticks every 66 us and is appended to valid frames
// - commands 94, 80 start a chain; 84 ends the chain
// - command 20 stops; a 00 is needed before the next command
// - contend bit set makes the poll logic join the next poll
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`include "iss_map.svh"
module iss_status_regs #(
  parameter int IDLE_CYC = `ISS_IDLE_US * `ISS_CLK_MHZ,
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // network and hdlc events
  input wire iss_pkg::iss_poll_type pollEv,
  input wire iss_pkg::iss_rx_type rxEv,
  input wire logic rxLine,
  input wire logic unsolMsgEnd,
  input wire logic solicited,
  input wire logic txFrameOk,
  input wire logic txFrameUrun,
  input wire logic txHoldWrite,
  input wire logic txHoldTaken,
  // chain engine
  input wire logic inputInstr,
  input wire logic outputInstr,
  input wire logic instrStart,
  input wire logic [ADDR_W-1:0] instrAddr,
  output iss_pkg::iss_mem_type memPort,
  output logic instrDone,
  output logic [7:0] command,
  output logic chainStart,
  output logic chainStartUnsol,
  output logic chainEnd,
  output logic seqStop,
  output logic joinPoll,
  output logic timeAppend,
  output logic [7:0] timeByte
);
  localparam logic [11:0] TICK_LAST = 12'(`ISS_TICK_CYC - 1);
  localparam int IW = $clog2(IDLE_CYC + 1);

  // decode of a register index from a bus byte address
  function automatic logic [7:0] regIdx(input logic [31:0] a);
    regIdx = a[9:2];
  endfunction

  iss_pkg::iss_cstate_type cstate_q, cstate_d;
  logic [7:0] cmd_q;
  logic armed_q;
  logic unsol_q, stuck_q, chDone_q, possDef_q;
  logic dTxFail_q, pTxFail_q, rxFail_q, rxGood_q;
  logic [IW-1:0] idleCnt_q;
  logic line_q;
  logic [7:0] rxHold_q;
  logic rxFull_q, overrun_q, txFull_q;
  logic [4:0] evt_q; // set means the active-low bit reads zero
  logic [2:0] low3_q;
  logic solic_q;
  logic [11:0] tick_q;
  logic [7:0] time_q;
  logic rdyBuf_q, anyBuf_q, txReqBuf_q;
  logic [ADDR_W-1:0] memAddr_q;
  logic memWe_q;
  logic [7:0] memData_q;
  logic [31:0] rdata_q;
  logic done_q, start_q, startU_q, end_q, stop_q;
  logic tapp_q;

  // ahb address phase decode
  wire addrPh = hsel & htrans[1] & hready;
  wire [7:0] idx = regIdx(haddr);
  wire wrHit = addrPh & hwrite;
  wire rdHit = addrPh & ~hwrite;
  logic dWr_q;
  logic [7:0] dIdx_q;
  // write data arrives one cycle after its address phase
  wire cmdWr = dWr_q & (dIdx_q == `ISS_IDX_CMD_IDX);
  wire [7:0] wv = hwdata[7:0];
  wire rdIface = rdHit & (idx == `ISS_IDX_IFACE);
  wire rdHold = rdHit & (idx == `ISS_IDX_RXHOLD);
  wire rdEvt = rdHit & (idx == `ISS_IDX_EVENT);

  // command decode; a stopped sequencer takes only the prime value
  wire cmdTake = cmdWr & (armed_q | wv == `ISS_CMD_PRIME);
  wire pollNew = wv[`ISS_BIT_POLL];
  wire pollOff = cmdTake & ~pollNew;
  wire pollOn = cmdTake & pollNew & ~cmd_q[`ISS_BIT_POLL];
  wire isStart = cmdTake & wv[`ISS_BIT_EXEC] & ~wv[`ISS_BIT_STOP];
  wire isStop = cmdTake & wv[`ISS_BIT_STOP];
  wire isEnd = cmdTake & (wv == `ISS_CMD_END);

  // mode edges of the chain engine
  wire toUnsol = solic_q & ~solicited;
  wire toSolic = ~solic_q & solicited;
  wire owner = cstate_q == iss_pkg::CS_OWN;

  // receive frame outcome at the closing flag
  wire frmErr = rxEv.crcErr | rxEv.abortErr | overrun_q;
  wire frmOk = rxEv.frameEnd & ~frmErr;
  wire frmBad = rxEv.frameEnd & frmErr;
  wire seqTake = memWe_q; // sequencer fetch empties holding reg
  wire holdTake = rdHold | seqTake;

  // live event bits and the summary
  wire rxRdy_n = ~rxFull_q;
  wire txReq_n = txFull_q;
  wire anyEv_n = ~(|evt_q) & rxRdy_n & txReq_n;
  wire [7:0] evtRd = {~evt_q[4:1], 1'b1, rxRdy_n, txReq_n, anyEv_n};
  wire [7:0] statRd = {4'h0, rxEv.inFrame, low3_q};
  wire [7:0] chainRd = {chDone_q, cstate_q, possDef_q, dTxFail_q,
                        pTxFail_q, rxFail_q, rxGood_q};
  wire [7:0] ifaceRd = {6'h00, stuck_q, unsol_q};

  // read mux for the address phase
  logic [7:0] rdMux;
  always_comb begin
    unique case (idx)
      `ISS_IDX_CHAIN: rdMux = chainRd;
      `ISS_IDX_IFACE: rdMux = ifaceRd;
      `ISS_IDX_TIME: rdMux = time_q;
      `ISS_IDX_RXHOLD: rdMux = rxHold_q;
      `ISS_IDX_EVENT: rdMux = evtRd;
      `ISS_IDX_RXSTAT: rdMux = statRd;
      default: rdMux = 8'h00;
    endcase
  end

  // ahb data phase: zero wait, always okay
  always_ff @(posedge clk) begin
    if (rst) begin
      dWr_q <= 1'b0;
      dIdx_q <= `ISS_RST_BYTE;
      rdata_q <= 32'h0000_0000;
    end else begin
      dWr_q <= wrHit;
      dIdx_q <= idx;
      if (rdHit) begin
        rdata_q <= {24'h00_0000, rdMux};
      end
    end
  end

  // next contention state of the poll logic
  always_comb begin
    cstate_d = cstate_q;
    if (pollOff) begin
      cstate_d = iss_pkg::CS_IDLE;
    end else if (pollOn) begin
      cstate_d = iss_pkg::CS_WAIT;
    end else if (cmd_q[`ISS_BIT_POLL] & pollEv.pollWon) begin
      cstate_d = iss_pkg::CS_OWN;
    end else if (cmd_q[`ISS_BIT_POLL] & pollEv.pollLost) begin
      cstate_d = iss_pkg::CS_LOST;
    end
  end

  // command register and command pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q <= `ISS_RST_BYTE;
      armed_q <= 1'b1;
      cstate_q <= iss_pkg::CS_IDLE;
      start_q <= 1'b0;
      startU_q <= 1'b0;
      end_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (cmdTake) begin
        cmd_q <= wv;
        armed_q <= ~isStop;
      end
      cstate_q <= cstate_d;
      start_q <= isStart & ~isEnd;
      startU_q <= isStart & wv[`ISS_BIT_UNSCH] & ~isEnd;
      end_q <= isEnd;
      stop_q <= isStop;
    end
  end

  // interface status: unsolicited input and stuck line
  always_ff @(posedge clk) begin
    if (rst) begin
      unsol_q <= 1'b0;
      stuck_q <= 1'b0;
      idleCnt_q <= '0;
      line_q <= 1'b0;
    end else begin
      line_q <= rxLine;
      // a message end in the read cycle survives the clear
      unsol_q <= unsolMsgEnd | (unsol_q & ~rdIface);
      if (rxLine != line_q) begin
        idleCnt_q <= '0;
        stuck_q <= 1'b0;
      end else if (rxLine) begin
        if (idleCnt_q != IW'(IDLE_CYC)) begin
          idleCnt_q <= idleCnt_q + 1'b1;
        end else begin
          stuck_q <= 1'b1;
        end
      end
    end
  end

  // chain status flags; each set wins over its clear
  always_ff @(posedge clk) begin
    if (rst) begin
      solic_q <= 1'b0;
      chDone_q <= 1'b0;
      possDef_q <= 1'b0;
      dTxFail_q <= 1'b0;
      pTxFail_q <= 1'b0;
      rxFail_q <= 1'b0;
      rxGood_q <= 1'b0;
    end else begin
      solic_q <= solicited;
      chDone_q <= (toUnsol & ~cmd_q[`ISS_BIT_POLL])
        | (chDone_q & ~pollOn & ~toSolic);
      possDef_q <= (owner & pollEv.pollLenBit)
        | (possDef_q & ~pollOff);
      dTxFail_q <= (owner & pollEv.cmdTxActive & pollEv.rxDataBit)
        | (dTxFail_q & ~pollOff);
      pTxFail_q <= (pollEv.pollActive & pollEv.dataLenBit)
        | (pTxFail_q & ~pollOff);
      rxFail_q <= frmBad
        | (rxFail_q & ~pollEv.pollStart & ~toSolic);
      rxGood_q <= frmOk
        | (rxGood_q & ~pollEv.pollStart & ~toSolic);
    end
  end

  // receive holding register with overrun tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      rxHold_q <= `ISS_RST_BYTE;
      rxFull_q <= 1'b0;
      overrun_q <= 1'b0;
      txFull_q <= 1'b0;
    end else begin
      if (rxEv.byteValid) begin
        rxHold_q <= rxEv.rxByte;
      end
      rxFull_q <= rxEv.byteValid | (rxFull_q & ~holdTake);
      if (rxEv.frameEnd) begin
        overrun_q <= 1'b0;
      end else if (rxEv.byteValid & rxFull_q & ~holdTake) begin
        overrun_q <= 1'b1;
      end
      txFull_q <= txHoldWrite | (txFull_q & ~txHoldTaken);
    end
  end

  // accumulated event bits seven to four, cleared by a read; bit three is never set and reads one
  wire [4:0] evtSet = {frmOk, frmBad, txFrameOk, txFrameUrun, 1'b0};
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_q <= 5'h00;
      low3_q <= 3'h7;
    end else begin
      evt_q <= evtSet | (evt_q & ~{5{rdEvt}});
      if (frmOk) begin
        low3_q <= rxEv.residual;
      end else if (frmBad) begin
        low3_q <= ~{rxEv.abortErr, overrun_q, rxEv.crcErr};
      end
    end
  end

  // buffered copies pace the input and output instructions
  always_ff @(posedge clk) begin
    if (rst) begin
      rdyBuf_q <= 1'b1;
      anyBuf_q <= 1'b1;
      txReqBuf_q <= 1'b1;
    end else begin
      rdyBuf_q <= rxRdy_n;
      anyBuf_q <= anyEv_n;
      txReqBuf_q <= txReq_n;
    end
  end

  // store a received byte into dual-port memory per buffered ready
  wire doStore = inputInstr & ~rdyBuf_q & rxFull_q & ~memWe_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      memAddr_q <= '0;
      memWe_q <= 1'b0;
      memData_q <= `ISS_RST_BYTE;
      done_q <= 1'b0;
    end else begin
      memWe_q <= doStore;
      if (doStore) begin
        memData_q <= rxHold_q;
      end
      if (instrStart) begin
        memAddr_q <= instrAddr;
      end else if (memWe_q) begin
        memAddr_q <= memAddr_q + 1'b1;
      end
      done_q <= (inputInstr | outputInstr) & ~anyBuf_q
        & ~done_q;
    end
  end

  // free-running time byte and its append strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_q <= 12'h000;
      time_q <= `ISS_RST_BYTE;
      tapp_q <= 1'b0;
    end else begin
      if (tick_q == TICK_LAST) begin
        tick_q <= 12'h000;
        time_q <= time_q + 8'h01;
      end else begin
        tick_q <= tick_q + 12'h001;
      end
      tapp_q <= frmOk;
    end
  end

  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign memPort.wrEn = memWe_q;
  assign memPort.rdReq = outputInstr & ~txReqBuf_q;
  assign memPort.addr = 16'(memAddr_q);
  assign memPort.wrData = memData_q;
  assign instrDone = done_q;
  assign command = cmd_q;
  assign chainStart = start_q;
  assign chainStartUnsol = startU_q;
  assign chainEnd = end_q;
  assign seqStop = stop_q;
  assign joinPoll = cmd_q[`ISS_BIT_POLL] & ~owner;
  assign timeAppend = tapp_q;
  assign timeByte = time_q;
  wire unusedBits = &hsize;
endmodule

// file: tb/iss_net_model.sv
// far-side model: hdlc receiver events, poll logic events, line level
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/100ps
module iss_net_model (
  input wire logic clk,
  output iss_pkg::iss_poll_type pollEv,
  output iss_pkg::iss_rx_type rxEv,
  output logic rxLine
);
  // quiet network at time zero
  initial begin
    pollEv = '0;
    rxEv = '0;
    rxLine = 1'b0;
  end
  // one-cycle poll event, bits in struct order
  task poll(input logic [7:0] ev);
    pollEv <= ev;
    @(posedge clk);
    pollEv <= '0;
    @(posedge clk);
  endtask
  // receive line level
  task line(input logic v);
    rxLine <= v;
  endtask
  // frame of n bytes, then the closing flag with its status
  task frame(input logic [15:0] b, input int n, input logic crc,
      input logic [2:0] res);
    rxEv.inFrame <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      rxEv.byteValid <= 1'b1;
      rxEv.rxByte <= b[8*i+:8];
      @(posedge clk);
      rxEv.byteValid <= 1'b0;
      rxEv.rxByte <= ~b[8*i+:8]; // no stale byte outside a strobe
      repeat (3) @(posedge clk);
    end
    rxEv.frameEnd <= 1'b1;
    rxEv.crcErr <= crc;
    rxEv.residual <= res;
    @(posedge clk);
    rxEv.frameEnd <= 1'b0;
    rxEv.inFrame <= 1'b0;
    rxEv.residual <= ~res;
    @(posedge clk);
  endtask
endmodule

// file: tb/iss_status_props.sv
// checker for the status bank: bus answers, command decoding, time byte
// assumes it is bound to iss_status_regs and sees only its ports
`timescale 1ns/100ps
module iss_status_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] command,
  input wire logic chainStart,
  input wire logic chainEnd,
  input wire logic seqStop,
  input wire logic joinPoll,
  input wire logic [7:0] timeByte
);
  logic cmdWr_q;
  wire logic taken = hsel && htrans[1] && hready;
  // remember an address phase aimed at the command register
  always_ff @(posedge clk) begin
    if (rst) cmdWr_q <= 1'b0;
    else cmdWr_q <= taken && hwrite && haddr == 32'h0000_0044;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // data phase that writes value v to the command register
  sequence s_cmd(logic [7:0] v);
    cmdWr_q && hwdata[7:0] == v;
  endsequence
  chk_start_cmd: assert property (
    s_cmd(8'h80) ##0 command != 8'h20 |=> chainStart)
    else $error("no chain start");
  chk_end_cmd: assert property (
    s_cmd(8'h84) ##0 command != 8'h20 |=> chainEnd && command == 8'h84)
    else $error("no chain end");
  chk_stop_cmd: assert property (
    s_cmd(8'h20) ##0 command != 8'h20 |=> seqStop)
    else $error("no stop pulse");
  chk_stop_lock: assert property (
    command == 8'h20 && cmdWr_q && hwdata[7:0] != 8'h00
    |=> command == 8'h20 && !chainStart)
    else $error("command taken while stopped");
  chk_join_poll: assert property (
    $rose(command[4]) |-> ##[0:2] joinPoll)
    else $error("contend bit not joining poll");
  chk_time_step: assert property (
    $changed(timeByte) |-> timeByte == 8'($past(timeByte) + 8'h01))
    else $error("time byte jumped");
  chk_unmapped_zero: assert property (
    taken && !hwrite && haddr == 32'h0000_0048 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_read_okay: assert property (
    taken && !hwrite |=> hreadyout && !hresp && hrdata[31:8] == 24'h00_0000)
    else $error("bad read answer");
endmodule
bind iss_status_regs iss_status_props chk_u (.clk, .rst, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp, .hrdata,
  .command, .chainStart, .chainEnd, .seqStop, .joinPoll, .timeByte);

// file: tb/tb_iss_status_regs.sv
// self-checking bench for the status register bank
// assumes one 50 MHz clock and the far-side model iss_net_model
`timescale 1ns/100ps
`include "iss_map.svh"
module tb_iss_status_regs;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic unsolMsgEnd = 1'b0;
  logic solicited = 1'b0;
  logic [3:0] txEv = 4'h0; // ok, underrun, hold write, hold taken
  logic inputInstr = 1'b0;
  logic outputInstr = 1'b0;
  logic instrStart = 1'b0;
  logic [15:0] instrAddr = '0;
  logic hreadyout, chainStart, chainEnd, seqStop, joinPoll, rxLine;
  logic hresp, chainStartUnsol, instrDone, timeAppend;
  logic [7:0] timeByte;
  logic [31:0] hrdata;
  logic [7:0] command;
  iss_pkg::iss_mem_type memPort;
  iss_pkg::iss_poll_type pollEv;
  iss_pkg::iss_rx_type rxEv;
  int nMismatch = 0;
  int samplesChecked = 0;
  int cyc = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  iss_status_regs #(.IDLE_CYC(20)) dut_u (.clk, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .pollEv, .rxEv, .rxLine, .unsolMsgEnd,
    .solicited, .txFrameOk(txEv[3]), .txFrameUrun(txEv[2]),
    .txHoldWrite(txEv[1]), .txHoldTaken(txEv[0]), .inputInstr,
    .outputInstr, .instrStart, .instrAddr, .memPort, .instrDone,
    .command, .chainStart, .chainStartUnsol, .chainEnd, .seqStop,
    .joinPoll, .timeAppend, .timeByte);
  iss_net_model net_u (.clk, .pollEv, .rxEv, .rxLine);
  // compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one ahb-lite single transfer on a register index
  task bus(input logic w, input logic [7:0] ix, input logic [7:0] d,
      output logic [7:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, ix, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask
  // read and compare
  task rd(input logic [7:0] ix, input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b0, ix, 8'h00, v);
    chk(v, exp);
    chk({7'h00, hresp}, 8'h00);
  endtask
  // write, then one more edge so the command pulses can be sampled
  task wr(input logic [7:0] ix, input logic [7:0] d);
    logic [7:0] v;
    bus(1'b1, ix, d, v);
    @(posedge clk);
  endtask
  // one-cycle pulse on the transmit event lines
  task pulseTx(input logic [3:0] m);
    txEv <= m;
    @(posedge clk);
    txEv <= 4'h0;
  endtask
  // reset values, a read-only write and an unmapped index
  task testRegs;
    rd(`ISS_IDX_CHAIN, 8'h00);
    rd(`ISS_IDX_EVENT, 8'hfc);
    rd(`ISS_IDX_RXSTAT, 8'h07);
    wr(`ISS_IDX_CHAIN, 8'hff);
    rd(`ISS_IDX_CHAIN, 8'h00);
    rd(8'h12, 8'h00);
  endtask
  // command codes, stop lock and contention flags
  task testCmds;
    wr(`ISS_IDX_IFACE, `ISS_CMD_START);
    chk({7'h00, chainStart}, 8'h01);
    chk({7'h00, chainStartUnsol}, 8'h00);
    solicited <= 1'b1;
    wr(`ISS_IDX_IFACE, `ISS_CMD_END);
    chk({7'h00, chainEnd}, 8'h01);
    solicited <= 1'b0;
    rd(`ISS_IDX_CHAIN, 8'h80);
    solicited <= 1'b1;
    rd(`ISS_IDX_CHAIN, 8'h00);
    wr(`ISS_IDX_IFACE, `ISS_CMD_STOP);
    chk({7'h00, seqStop}, 8'h01);
    wr(`ISS_IDX_IFACE, `ISS_CMD_START);
    chk(command, `ISS_CMD_STOP);
    wr(`ISS_IDX_IFACE, `ISS_CMD_PRIME);
    wr(`ISS_IDX_IFACE, `ISS_CMD_START_POLL);
    chk({7'h00, chainStartUnsol}, 8'h01);
    rd(`ISS_IDX_CHAIN, 8'h20);
    chk({7'h00, joinPoll}, 8'h01);
    net_u.poll(8'h20); // poll lost
    rd(`ISS_IDX_CHAIN, 8'h40);
    net_u.poll(8'h40); // poll won
    rd(`ISS_IDX_CHAIN, 8'h60);
    net_u.poll(8'h08); // poll length bit seen by the owner
    net_u.poll(8'h03); // data bit on our own command frame
    net_u.poll(8'h14); // data length bit inside a poll
    rd(`ISS_IDX_CHAIN, 8'h7c);
    wr(`ISS_IDX_IFACE, `ISS_CMD_START);
    rd(`ISS_IDX_CHAIN, 8'h00);
  endtask
  // frames, holding register, overrun, accumulation, tx flags
  task testFrames;
    net_u.frame(16'h005a, 1, 1'b0, 3'd5);
    rd(`ISS_IDX_RXHOLD, 8'h5a);
    rd(`ISS_IDX_RXSTAT, 8'h05);
    net_u.frame(16'h1122, 2, 1'b1, 3'd0);
    rd(`ISS_IDX_EVENT, 8'h38);
    rd(`ISS_IDX_RXSTAT, 8'h04);
    rd(`ISS_IDX_RXHOLD, 8'h22);
    rd(`ISS_IDX_EVENT, 8'hfc);
    rd(`ISS_IDX_CHAIN, 8'h03);
    pulseTx(4'hd);
    rd(`ISS_IDX_EVENT, 8'hcc);
    // empty transmit holding makes an output instruction fetch
    outputInstr <= 1'b1;
    @(posedge clk);
    chk({7'h00, memPort.rdReq}, 8'h01);
    pulseTx(4'h2);
    rd(`ISS_IDX_EVENT, 8'hff);
    chk({7'h00, memPort.rdReq}, 8'h00);
    outputInstr <= 1'b0;
  endtask
  // unsolicited message flag and stuck line flag
  task testIface;
    unsolMsgEnd <= 1'b1;
    @(posedge clk);
    unsolMsgEnd <= 1'b0;
    rd(`ISS_IDX_IFACE, 8'h01);
    rd(`ISS_IDX_IFACE, 8'h00);
    net_u.line(1'b1);
    repeat (25) @(posedge clk);
    rd(`ISS_IDX_IFACE, 8'h02);
    net_u.line(1'b0);
    rd(`ISS_IDX_IFACE, 8'h00);
  endtask
  // input instruction stores a received byte in memory
  task testInput;
    int i;
    instrAddr <= 16'h0100;
    inputInstr <= 1'b1;
    instrStart <= 1'b1;
    @(posedge clk);
    instrStart <= 1'b0;
    fork
      net_u.frame(16'h0033, 1, 1'b0, 3'd0);
      begin
        for (i = 0; i < 20 && memPort.wrEn !== 1'b1; i++) @(negedge clk);
        chk({7'h00, memPort.wrEn}, 8'h01);
        chk(memPort.wrData, 8'h33);
        chk(memPort.addr[15:8], 8'h01);
        for (i = 0; i < 20 && instrDone !== 1'b1; i++) @(negedge clk);
        chk({7'h00, instrDone}, 8'h01);
        for (i = 0; i < 20 && timeAppend !== 1'b1; i++) @(negedge clk);
        chk({7'h00, timeAppend}, 8'h01);
      end
    join
    inputInstr <= 1'b0;
  endtask
  // samples taken exactly one tick period apart
  task testTime;
    logic [7:0] t0;
    logic [7:0] t1;
    bus(1'b0, `ISS_IDX_TIME, 8'h00, t0);
    repeat (`ISS_TICK_CYC - 3) @(posedge clk);
    bus(1'b0, `ISS_IDX_TIME, 8'h00, t1);
    chk(t1 - t0, 8'h01);
  endtask
  // counts and verdict
  task giveVerdict;
    $display("checked %0d mismatched %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    testRegs;
    $display("regs test ended");
    testCmds;
    $display("command test ended");
    testFrames;
    $display("frame test ended");
    testIface;
    $display("interface test ended");
    testInput;
    $display("input test ended");
    testTime;
    $display("time test ended");
    giveVerdict;
  end
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      nMismatch++;
      giveVerdict;
    end
  end
endmodule
